// *** dslc_pkg.sv ***
// constants shared by the serial load control of a dual output converter
// assumes a system clock of 10 MHz and a link clock from the host serial port
package dslc_pkg;
   localparam int DSLC_WORD_W = 24;
   localparam int DSLC_DATA_W = 16;
   localparam int DSLC_ADDR_LSB = 16;
   localparam int DSLC_ADDR_W = 3;
   localparam int DSLC_UNI_BIT = 19;
   localparam logic [DSLC_ADDR_W-1:0] DSLC_ADDR_A = 3'h0;
   localparam logic [DSLC_ADDR_W-1:0] DSLC_ADDR_B = 3'h2;
   localparam logic [DSLC_ADDR_W-1:0] DSLC_ADDR_ALL = 3'h4;
   localparam logic [DSLC_DATA_W-1:0] DSLC_CODE_RESET = 16'h0000;
   localparam logic [DSLC_DATA_W-1:0] DSLC_ZERO_OB = 16'h0000;
   localparam logic [DSLC_DATA_W-1:0] DSLC_MID_OB = 16'h8000;
   localparam logic [4:0] DSLC_CNT_RESET = 5'h00;
   localparam int DSLC_SCLK_MAX_MHZ = 30;
   typedef enum logic [1:0] {DSLC_UNI, DSLC_BIP_OB, DSLC_BIP_TC} dslc_coding_t;
endpackage

// *** dslc_link.sv ***
// link side shift register, clocked by the host serial clock
// assumes frame sync is low only while the host is shifting a word
`timescale 1ns/1ps
module dslc_link
   import dslc_pkg::*;
(
   input wire logic i_sclk,
   input wire logic i_sync_n,
   input wire logic i_rst_n,
   input wire logic i_serial_data_in,
   output logic [dslc_pkg::DSLC_WORD_W-1:0] o_word,
   output logic o_word_toggle,
   output logic o_serial_data_out
);
   logic [DSLC_WORD_W-1:0] shift;
   logic [4:0] count;
   // shift on falling edges while the frame is open
   always_ff @(negedge i_sclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         shift <= '0;
         count <= DSLC_CNT_RESET;
      end else if (!i_sync_n) begin
         shift <= {shift[DSLC_WORD_W-2:0], i_serial_data_in};
         count <= (count == 5'(DSLC_WORD_W)) ? count : count + 5'h01;
      end
   end
   // rising frame sync closes the word; the toggle carries it across
   always_ff @(posedge i_sync_n or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_word <= '0;
         o_word_toggle <= 1'b0;
      end else if (count != DSLC_CNT_RESET) begin
         o_word <= shift;
         o_word_toggle <= ~o_word_toggle;
      end
   end
   // readback path: msb driven on rising edge, valid at next fall
   always_ff @(posedge i_sclk or negedge i_rst_n) begin
      if (!i_rst_n) o_serial_data_out <= 1'b0;
      else o_serial_data_out <= shift[DSLC_WORD_W-1];
   end
endmodule

// *** dslc_top.sv ***
// system side: input and DAC registers, load and clear control
// assumes word is stable many system clocks before its toggle is seen
`timescale 1ns/1ps
module dslc_top
   import dslc_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_sclk,
   input wire logic i_sync_n,
   input wire logic i_serial_data_in,
   input wire logic i_load_outputs_n,
   input wire logic i_clear_outputs_n,
   input wire logic i_clear_mid,
   input wire logic i_coding_select,
   output logic [dslc_pkg::DSLC_DATA_W-1:0] o_dac_a,
   output logic [dslc_pkg::DSLC_DATA_W-1:0] o_dac_b,
   output logic o_serial_data_out
);
   import dslc_pkg::*;

   logic [DSLC_WORD_W-1:0] link_word;
   logic link_toggle;
   logic link_sdo;
   logic [2:0] tog_sync;
   logic [2:0] ld_sync;
   logic [1:0] clr_sync;
   logic [1:0] cs_sync;
   logic [DSLC_DATA_W-1:0] in_a;
   logic [DSLC_DATA_W-1:0] in_b;
   logic pend_a;
   logic pend_b;
   logic sdo_sync;
   logic [1:0] mid_sync;
   logic [DSLC_WORD_W-1:0] word_hold;

   dslc_link u_link (
      .i_sclk(i_sclk),
      .i_sync_n(i_sync_n),
      .i_rst_n(i_rst_n),
      .i_serial_data_in(i_serial_data_in),
      .o_word(link_word),
      .o_word_toggle(link_toggle),
      .o_serial_data_out(link_sdo)
   );

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tog_sync <= '0;
         ld_sync <= 3'h7;
         clr_sync <= 2'h3;
         cs_sync <= 2'h3;
         mid_sync <= 2'h0;
         sdo_sync <= 1'b0;
         word_hold <= '0;
      end else begin
         mid_sync <= {mid_sync[0], i_clear_mid};
         sdo_sync <= link_sdo;
         tog_sync <= {tog_sync[1:0], link_toggle};
         ld_sync <= {ld_sync[1:0], i_load_outputs_n};
         clr_sync <= {clr_sync[0], i_clear_outputs_n};
         cs_sync <= {cs_sync[0], i_coding_select};
         word_hold <= link_word;
      end
   end

   // word_hold samples a bus stable since before the toggle edge
   wire word_new = tog_sync[2] ^ tog_sync[1];
   wire [DSLC_ADDR_W-1:0] w_addr =
      word_hold[DSLC_ADDR_LSB +: DSLC_ADDR_W];
   wire [DSLC_DATA_W-1:0] w_data = word_hold[DSLC_DATA_W-1:0];
   wire w_uni = word_hold[DSLC_UNI_BIT];
   wire hit_a = word_new && (w_addr == DSLC_ADDR_A || w_addr == DSLC_ADDR_ALL);
   wire hit_b = word_new && (w_addr == DSLC_ADDR_B || w_addr == DSLC_ADDR_ALL);
   wire load_low = !ld_sync[1];
   wire load_fall = ld_sync[2] && !ld_sync[1];
   wire clearing = !clr_sync[1];

   // coding follows the range bit of the word being written
   wire dslc_coding_t coding = w_uni ? DSLC_UNI :
      (cs_sync[1] ? DSLC_BIP_OB : DSLC_BIP_TC);

   // internal DAC code is offset binary; twos complement flips the msb
   function automatic logic [DSLC_DATA_W-1:0] to_dac(
      input logic [DSLC_DATA_W-1:0] code, input dslc_coding_t c);
      to_dac = (c == DSLC_BIP_TC) ? {~code[DSLC_DATA_W-1],
         code[DSLC_DATA_W-2:0]} : code;
   endfunction

   wire [DSLC_DATA_W-1:0] clr_code = mid_sync[1] ? DSLC_MID_OB : DSLC_ZERO_OB;
   // input registers keep the converted code, so a later load needs no range
   wire [DSLC_DATA_W-1:0] next_in_a = hit_a ? to_dac(w_data, coding) : in_a;
   wire [DSLC_DATA_W-1:0] next_in_b = hit_b ? to_dac(w_data, coding) : in_b;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         in_a <= DSLC_CODE_RESET;
         in_b <= DSLC_CODE_RESET;
         pend_a <= 1'b0;
         pend_b <= 1'b0;
      end else begin
         in_a <= next_in_a;
         in_b <= next_in_b;
         // load high: hold the update pending
         pend_a <= hit_a ? !load_low : (load_fall ? 1'b0 : pend_a);
         pend_b <= hit_b ? !load_low : (load_fall ? 1'b0 : pend_b);
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_dac_a <= DSLC_CODE_RESET;
         o_dac_b <= DSLC_CODE_RESET;
         o_serial_data_out <= 1'b0;
      end else begin
         o_serial_data_out <= sdo_sync;
         if (clearing) begin
            o_dac_a <= clr_code;
            o_dac_b <= clr_code;
         end else begin
            // load low: update at frame end fall: pending ones at once
            if ((hit_a && load_low) || (load_fall && pend_a))
               o_dac_a <= next_in_a;
            if ((hit_b && load_low) || (load_fall && pend_b))
               o_dac_b <= next_in_b;
         end
      end
   end

   sequence s_new_a;
      hit_a && load_low && !clearing;
   endsequence

   load_low_upd_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      s_new_a |=> (o_dac_a == $past(to_dac(w_data, coding))))
      else $error("dac a not updated at frame end");
   hold_high_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (hit_a && !load_low && !load_fall && !clearing) |=> $stable(o_dac_a))
      else $error("dac a changed while load held high");
   sim_load_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (load_fall && pend_a && pend_b && !word_new && !clearing) |=>
      (o_dac_a == $past(in_a) && o_dac_b == $past(in_b)))
      else $error("pending outputs not loaded together");
   clear_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      clearing |=> (o_dac_a == $past(clr_code) && o_dac_b == $past(clr_code)))
      else $error("clear did not force outputs");
   uni_code_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (s_new_a and w_uni) |=> (o_dac_a == $past(w_data)))
      else $error("unipolar coding not straight binary");
   bip_code_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (hit_a && load_low && !clearing && !w_uni && cs_sync[1]) |=>
      (o_dac_a == $past(w_data)))
      else $error("offset binary code not passed through");
   word_latch_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      word_new |-> (word_hold == link_word))
      else $error("word not latched at frame end");
   shift_in_a: assert property (@(negedge i_sclk) disable iff (!i_rst_n)
      !i_sync_n |=> (u_link.shift[0] == $past(i_serial_data_in)))
      else $error("serial bit not shifted in");
   sdo_edge_a: assert property (@(posedge i_sclk) disable iff (!i_rst_n)
      ##1 (link_sdo == $past(u_link.shift[DSLC_WORD_W-1])))
      else $error("serial output not driven on rising edge");
endmodule

// *** dslc_host_model.sv ***
// host serial port that writes 24 bit words into the converter
// assumes the caller spaces frames; serial clock stands high between frames
`timescale 1ns/1ps
module dslc_host_model (
   output logic o_sclk,
   output logic o_sync_n,
   output logic o_serial_data_in
);
   // 125 ns period keeps the link well under its top rate
   localparam realtime HALF = 62.5;
   initial begin
      o_sclk = 1'b1;
      o_sync_n = 1'b1;
      o_serial_data_in = 1'b0;
   end
   task automatic send(input logic [23:0] word);
      integer i;
      o_sync_n = 1'b0; // bits only count inside the low frame
      for (i = 23; i >= 0; i--) begin
         o_serial_data_in = word[i]; // set while clock high, stable at fall
         #(HALF);
         o_sclk = 1'b0;
         #(HALF);
         o_sclk = 1'b1;
      end
      #(HALF);
      o_sync_n = 1'b1; // frame ends on the rising edge
      // released line shows the inverse so a stale bit cannot pass
      o_serial_data_in = ~word[0];
      #700;
   endtask
endmodule

// *** dac_serial_load_control_tb.sv ***
// self-checking bench for the serial load control of the dual converter
// assumes the host model drives the link; bench drives system side inputs
`timescale 1ns/1ps
module dac_serial_load_control_tb;
   import dslc_pkg::*;
   typedef struct packed {
      logic cs; logic uni; logic [2:0] addr;
      logic [15:0] data; logic [15:0] ea; logic [15:0] eb;
   } dslc_row_t;
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_load_outputs_n = 1'b0;
   logic i_clear_outputs_n = 1'b1;
   logic i_clear_mid = 1'b0;
   logic i_coding_select = 1'b1;
   logic sclk, sync_n, serial_data_in, serial_data_out;
   logic [DSLC_DATA_W-1:0] o_dac_a, o_dac_b;
   int num_errors = 0;
   int comparisons = 0;
   // straight, offset and twos complement; twos complement flips the msb
   dslc_row_t rows [5] = '{
      '{1'b1, 1'b1, 3'h0, 16'h1234, 16'h1234, 16'h0000},
      '{1'b1, 1'b0, 3'h2, 16'hABCD, 16'h1234, 16'hABCD},
      '{1'b0, 1'b0, 3'h0, 16'h1234, 16'h9234, 16'hABCD},
      '{1'b0, 1'b1, 3'h4, 16'h00FF, 16'h00FF, 16'h00FF},
      '{1'b0, 1'b0, 3'h2, 16'h8001, 16'h00FF, 16'h0001}};
   always #50 i_clock = ~i_clock;
   dslc_host_model host (.o_sclk(sclk), .o_sync_n(sync_n),
      .o_serial_data_in(serial_data_in));
   dslc_top uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_sclk(sclk),
      .i_sync_n(sync_n), .i_serial_data_in(serial_data_in),
      .i_load_outputs_n(i_load_outputs_n),
      .i_clear_outputs_n(i_clear_outputs_n), .i_clear_mid(i_clear_mid),
      .i_coding_select(i_coding_select), .o_dac_a(o_dac_a),
      .o_dac_b(o_dac_b), .o_serial_data_out(serial_data_out));
   task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic both(input logic [15:0] ea, input logic [15:0] eb);
      chk("dac_a", ea, o_dac_a);
      chk("dac_b", eb, o_dac_b);
   endtask
   task automatic write(input logic uni, input logic [2:0] addr,
      input logic [15:0] data);
      host.send({4'h0, uni, addr, data});
      repeat (8) @(posedge i_clock);
   endtask
   task test_done;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      num_errors++;
      test_done();
   end
   initial begin
      repeat (16) @(posedge i_clock);
      i_rst_n <= 1'b1;
      repeat (4) @(posedge i_clock);
      both(16'h0000, 16'h0000);
      $display("test reset done");
      foreach (rows[k]) begin
         @(posedge i_clock);
         i_coding_select <= rows[k].cs;
         write(rows[k].uni, rows[k].addr, rows[k].data);
         both(rows[k].ea, rows[k].eb);
         $display("test row %0d done", k);
      end
      // held load: nothing moves until its falling edge, then both together
      @(posedge i_clock);
      i_load_outputs_n <= 1'b1;
      i_coding_select <= 1'b1;
      write(1'b0, DSLC_ADDR_A, 16'h1111);
      write(1'b0, DSLC_ADDR_B, 16'h2222);
      both(16'h00FF, 16'h0001);
      @(posedge i_clock);
      i_load_outputs_n <= 1'b0;
      repeat (2) @(posedge i_clock);
      #1;
      chk("dac_a", 16'h00FF, o_dac_a);
      @(posedge i_clock);
      #1;
      both(16'h1111, 16'h2222);
      $display("test held load done");
      // clear wins over a write that arrives while it is low
      @(posedge i_clock);
      i_clear_mid <= 1'b1;
      i_clear_outputs_n <= 1'b0;
      repeat (6) @(posedge i_clock);
      both(16'h8000, 16'h8000);
      write(1'b1, DSLC_ADDR_ALL, 16'h5555);
      both(16'h8000, 16'h8000);
      $display("test clear done");
      // unused address, clear still low: only the serial output shows the last msb
      host.send(24'h8F0000);
      repeat (8) @(posedge i_clock);
      chk("sdo", 16'h0001, {15'h0000, serial_data_out});
      both(16'h8000, 16'h8000);
      $display("test serial out done");
      @(posedge i_clock);
      i_rst_n <= 1'b0;
      i_clear_outputs_n <= 1'b1;
      repeat (2) @(posedge i_clock);
      both(16'h0000, 16'h0000);
      i_rst_n <= 1'b1;
      repeat (2) @(posedge i_clock);
      #1;
      both(16'h0000, 16'h0000);
      $display("test mid reset done");
      test_done();
   end
endmodule
